// >>> core/sim_safety_input_monitor.sv
// safety door, emergency stop and latch release monitor with apb registers
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// R1: door channel mismatch two seconds is critical
// R2: status_a channel mismatch two seconds is critical
// R3: open door forces operation prohibited
// R4: latch door open and teach until release
// R5: closed release input clears both latches; the door latch only clears while the door is closed
// R6: open door keeps prohibit after teach cleared
// R7: other side closes door before release
// R8: other side selects auto before release
// R9: release input acknowledges teach mode entry
// R10: active status_a lights indicator and status
// R11: status_a clears after release then reset
// R12: open inputs mean stop or prohibit
// R13: synchronise inputs, restart timer, hold errors
module sim_safety_input_monitor #(
  parameter int unsigned MISMATCH_CYCLES = sim_pkg::MISMATCH_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic door_input_a,
  input wire logic door_input_b,
  input wire logic status_a_contact_a_pin1,
  input wire logic status_a_contact_b_pin1,
  input wire logic latch_release_input,
  input wire logic teach_mode,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic status_a_led,
  output logic status_a,
  output logic operation_prohibited,
  output logic critical_error,
  output logic irq
);

  // three-stage synchronisers; a change counts when stages two and three agree
  localparam int unsigned NIN = 6;
  logic [NIN-1:0] rawIn;
  logic [NIN-1:0] s1_q, s2_q, s3_q, filt_q;
  assign rawIn = {teach_mode, latch_release_input, status_a_contact_b_pin1,
                  status_a_contact_a_pin1, door_input_b, door_input_a};

  always_ff @(posedge clk or negedge rst_n) begin // [R13]
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0; // open contacts at reset read as stop [R12]
    end else begin
      s1_q <= rawIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NIN; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          filt_q[i] <= s3_q[i];
        end
      end
    end
  end

  // closed contact is high; open (or unconnected) is low, meaning stop [R12]
  logic doorA, doorB, esA, esB, relClosed, teachIn;
  assign doorA = filt_q[0];
  assign doorB = filt_q[1];
  assign esA = filt_q[2];
  assign esB = filt_q[3];
  assign relClosed = filt_q[4];
  assign teachIn = filt_q[5];

  logic doorOpen, estopPressed;
  assign doorOpen = !(doorA && doorB); // [R3] [R12]
  assign estopPressed = !(esA && esB); // [R12]

  // saturating mismatch count step shared by both channel pairs, each with its own counter
  function automatic logic [sim_pkg::CNT_W-1:0] nextCount(input logic differ,
                                                         input logic [sim_pkg::CNT_W-1:0] cnt);
    if (!differ) begin
      nextCount = '0; // agreement restarts the timer
    end else if (cnt != sim_pkg::CNT_W'(MISMATCH_CYCLES)) begin
      nextCount = cnt + 1'b1;
    end else begin
      nextCount = cnt;
    end
  endfunction

  logic [sim_pkg::CNT_W-1:0] doorCnt_q, esCnt_q;
  always_ff @(posedge clk or negedge rst_n) begin // [R13]
    if (!rst_n) begin
      doorCnt_q <= '0;
      esCnt_q <= '0;
    end else begin
      doorCnt_q <= nextCount(doorA != doorB, doorCnt_q); // [R1]
      esCnt_q <= nextCount(esA != esB, esCnt_q); // [R2]
    end
  end

  logic doorTimeout, esTimeout;
  assign doorTimeout = (doorCnt_q == sim_pkg::CNT_W'(MISMATCH_CYCLES));
  assign esTimeout = (esCnt_q == sim_pkg::CNT_W'(MISMATCH_CYCLES));

  // critical errors hold until the block is reset
  logic doorErr_q, esErr_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      doorErr_q <= 1'b0;
      esErr_q <= 1'b0;
    end else begin
      if (doorTimeout) doorErr_q <= 1'b1; // [R1] [R13]
      if (esTimeout) esErr_q <= 1'b1; // [R2] [R13]
    end
  end

  // door and teach latches; an open door wins over release, but release wins over teach selection
  logic doorLatch_q, teachLatch_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      doorLatch_q <= 1'b1; // power-up counts as door unacknowledged
      teachLatch_q <= 1'b0;
    end else begin
      if (doorOpen) begin
        doorLatch_q <= 1'b1; // [R4]
      end else if (relClosed) begin
        doorLatch_q <= 1'b0; // [R5] [R7]
      end
      if (teachIn && !relClosed) begin
        teachLatch_q <= 1'b1; // [R4]
      end else if (relClosed) begin
        teachLatch_q <= 1'b0; // release acknowledges teach entry [R5] [R9] [R8]
      end
    end
  end

  // status_a: set while pressed, cleared by a reset command only once released
  logic status_a_q, resetCmd;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_a_q <= 1'b1; // boot in stop until a reset command
    end else if (estopPressed) begin
      status_a_q <= 1'b1; // [R10]
    end else if (resetCmd) begin
      status_a_q <= 1'b0; // [R11]
    end
  end

  // registered outputs
  logic prohibitNext;
  assign prohibitNext = doorOpen || doorLatch_q || teachLatch_q || status_a_q || doorErr_q || esErr_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_a_led <= 1'b1;
      status_a <= 1'b1;
      operation_prohibited <= 1'b1;
      critical_error <= 1'b0;
    end else begin
      status_a_led <= status_a_q || estopPressed; // [R10] [R11]
      status_a <= status_a_q || estopPressed; // [R10]
      operation_prohibited <= prohibitNext; // door still open keeps prohibit [R3] [R6] [R12]
      critical_error <= doorErr_q || esErr_q;
    end
  end

  // apb slave: zero wait states, unmapped addresses answer with pslverr
  logic apbAcc, apbWr, apbRd, hit;
  assign apbAcc = psel && penable;
  assign apbWr = apbAcc && pwrite;
  assign apbRd = apbAcc && !pwrite;
  assign hit = (paddr == sim_pkg::OFF_CTRL) || (paddr == sim_pkg::OFF_STAT) ||
               (paddr == sim_pkg::OFF_IRQST) || (paddr == sim_pkg::OFF_IRQMSK);
  assign resetCmd = apbWr && (paddr == sim_pkg::OFF_CTRL) && pwdata[sim_pkg::CTRL_RESET];

  // interrupt events; set wins over the read-clear
  logic [sim_pkg::EV_W-1:0] evt, irqSt_q, irqMsk_q;
  logic prevCrit_q, prevDoor_q;
  assign evt[sim_pkg::EV_CRIT] = (doorErr_q || esErr_q) && !prevCrit_q;
  assign evt[sim_pkg::EV_STATUS_A] = estopPressed && !status_a_q;
  assign evt[sim_pkg::EV_DOOR] = doorOpen && !prevDoor_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqSt_q <= '0;
      prevCrit_q <= 1'b0;
      prevDoor_q <= 1'b1; // filtered door reads open during reset, so no false edge after it
    end else begin
      prevCrit_q <= doorErr_q || esErr_q;
      prevDoor_q <= doorOpen;
      if (apbRd && paddr == sim_pkg::OFF_IRQST) begin
        irqSt_q <= evt;
      end else begin
        irqSt_q <= irqSt_q | evt;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqMsk_q <= sim_pkg::MSK_RESET;
    end else if (apbWr && paddr == sim_pkg::OFF_IRQMSK) begin
      irqMsk_q <= pwdata[sim_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqSt_q & irqMsk_q);
    end
  end

  // read data and response, registered in the setup cycle
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    case (paddr)
      sim_pkg::OFF_STAT: begin
        rdMux[sim_pkg::ST_DOOR_ERR] = doorErr_q;
        rdMux[sim_pkg::ST_STATUS_A_ERR] = esErr_q;
        rdMux[sim_pkg::ST_DOOR_LATCH] = doorLatch_q;
        rdMux[sim_pkg::ST_TEACH_LATCH] = teachLatch_q;
        rdMux[sim_pkg::ST_STATUS_A] = status_a_q;
        rdMux[sim_pkg::ST_PROHIBIT] = prohibitNext;
        rdMux[sim_pkg::ST_DOOR_OPEN] = doorOpen;
        rdMux[sim_pkg::ST_RELEASE] = relClosed;
      end
      sim_pkg::OFF_IRQST: rdMux[sim_pkg::EV_W-1:0] = irqSt_q;
      sim_pkg::OFF_IRQMSK: rdMux[sim_pkg::EV_W-1:0] = irqMsk_q;
      default: rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (psel && !penable) begin
        prdata <= rdMux;
      end
    end
  end

  // checks
  a_door_mismatch_err: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    doorTimeout |=> doorErr_q) else $error("door mismatch did not raise error");
  a_status_a_mismatch_err: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
    esTimeout |=> esErr_q) else $error("status_a mismatch did not raise error");
  a_door_prohibit: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    doorOpen |=> operation_prohibited) else $error("open door not prohibited");
  a_latch_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    (doorLatch_q && !relClosed) |=> doorLatch_q) else $error("door latch dropped");
  a_latch_release: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    (relClosed && !doorOpen && !teachIn) |=> (!doorLatch_q && !teachLatch_q))
    else $error("release did not clear latches");
  a_teach_door_open: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
    ($fell(teachLatch_q) && doorOpen) |=> operation_prohibited) else $error("teach clear ended prohibit");
  a_status_a_indicate: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
    estopPressed |=> (status_a_led && status_a)) else $error("status_a not indicated");
  a_status_a_recover: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    $fell(status_a_q) |-> ($past(resetCmd) && !$past(estopPressed))) else $error("status_a cleared wrongly");
  a_error_sticky: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    doorErr_q |=> doorErr_q) else $error("critical error not held");
  a_status_a_err_sticky: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    esErr_q |=> esErr_q) else $error("status_a critical error not held");
  a_timer_restart: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
    (doorA == doorB) |=> (doorCnt_q == '0)) else $error("door timer not restarted");
  a_crit_output: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
    (doorErr_q || esErr_q) |=> critical_error) else $error("critical error not reported");

  // latch checks; the door set term wins over a release in the same cycle, while release wins over teach entry
  a_door_latch_set: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    doorOpen |=> doorLatch_q) else $error("open door not latched");
  a_teach_latch_set: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    (teachIn && !relClosed) |=> teachLatch_q) else $error("teach entry not latched");
  a_teach_hold: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
    (teachLatch_q && !relClosed) |=> teachLatch_q) else $error("teach latch dropped");
  a_release_ack: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    (relClosed && teachLatch_q) |=> !teachLatch_q) else $error("release did not acknowledge teach");

  // stop handling; an open contact pair must never be read as running
  a_open_stop: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    estopPressed |=> status_a_q) else $error("pressed status_a not held in stop");
  a_status_a_dark: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    (!status_a_q && !estopPressed) |=> (!status_a_led && !status_a)) else $error("status_a indication stuck on");

  // recovery takes two steps: switch released, then a reset command while still released
  sequence s_switch_released;
    !estopPressed;
  endsequence
  sequence s_reset_issued;
    resetCmd && !estopPressed;
  endsequence
  a_status_a_exit: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    (s_switch_released ##1 s_reset_issued) |=> !status_a_q) else $error("status_a not left after reset command");

endmodule
`default_nettype wire

// >>> core/sim_pkg.sv
// shared constants for the safety input monitor
package sim_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // disagreement window in milliseconds and derived cycle count
  localparam int unsigned MISMATCH_MS = 2000;
  localparam int unsigned MISMATCH_CYC = (CLK_HZ / 1000) * MISMATCH_MS;
  localparam int unsigned CNT_W = 28;
  // register offsets (byte addresses)
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [11:0] OFF_IRQST = 12'h008;
  localparam logic [11:0] OFF_IRQMSK = 12'h00c;
  // control register fields
  localparam int unsigned CTRL_RESET = 0;
  // status register fields
  localparam int unsigned ST_DOOR_ERR = 0;
  localparam int unsigned ST_STATUS_A_ERR = 1;
  localparam int unsigned ST_DOOR_LATCH = 2;
  localparam int unsigned ST_TEACH_LATCH = 3;
  localparam int unsigned ST_STATUS_A = 4;
  localparam int unsigned ST_PROHIBIT = 5;
  localparam int unsigned ST_DOOR_OPEN = 6;
  localparam int unsigned ST_RELEASE = 7;
  // interrupt event bits
  localparam int unsigned EV_CRIT = 0;
  localparam int unsigned EV_STATUS_A = 1;
  localparam int unsigned EV_DOOR = 2;
  localparam int unsigned EV_W = 3;
  localparam logic [EV_W-1:0] MSK_RESET = 3'h0;
endpackage

// >>> tb/sim_switch_model.sv
// door, emergency stop, release and mode switch contacts facing the monitor
`timescale 1ns/1ns
`default_nettype none
module sim_switch_model (
  input wire logic doorClosed,
  input wire logic estopFree,
  input wire logic releaseClosed,
  input wire logic teachSel,
  input wire logic skewDoor,
  input wire logic skewEstop,
  output logic doorA,
  output logic doorB,
  output logic estopA,
  output logic estopB,
  output logic releasePin,
  output logic teachPin
);
  // both contacts of a pair follow one switch; skew breaks channel b only on command
  always_comb begin
    doorA = doorClosed;
    doorB = doorClosed ^ skewDoor;
    estopA = estopFree;
    estopB = estopFree ^ skewEstop;
    releasePin = releaseClosed;
    teachPin = teachSel;
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the safety input monitor
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, errQ;
  logic doorC, estF, relC, teachS, skD, skE, dA, dB, eA, eB, relP, teachP;
  logic estopLed, estopSt, prohib, critErr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic de, ee, dl, tl, es;
  int mismatches, cmp_count;

  sim_switch_model sw (.doorClosed(doorC), .estopFree(estF), .releaseClosed(relC), .teachSel(teachS),
    .skewDoor(skD), .skewEstop(skE), .doorA(dA), .doorB(dB), .estopA(eA), .estopB(eB), .releasePin(relP),
    .teachPin(teachP));
  // short mismatch window keeps the run brief
  sim_safety_input_monitor #(.MISMATCH_CYCLES(20)) DUT (.clk(clk), .rst_n(rst_n), .door_input_a(dA),
    .door_input_b(dB), .status_a_contact_a_pin1(eA), .status_a_contact_b_pin1(eB), .latch_release_input(relP),
    .teach_mode(teachP), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .status_a_led(estopLed), .status_a(estopSt),
    .operation_prohibited(prohib), .critical_error(critErr), .irq(irq));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one apb transfer; an idle edge at the end keeps back-to-back calls race free
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no wait limit here: only the watchdog may end a stalled transfer
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    errQ = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // status and outputs against the reference state kept in de/ee/dl/tl/es
  task automatic verify();
    logic p;
    p = es | ~doorC | dl | tl | de | ee;
    tick(8);
    apb(1'b0, sim_pkg::OFF_STAT, 32'h0);
    check(rd, {24'h0, relC, ~doorC, p, es, tl, dl, ee, de});
    check({31'h0, errQ}, 32'h0);
    check({28'h0, estopLed, estopSt, prohib, critErr}, {28'h0, es, es, p, de | ee});
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // the sequence needs well under 10k cycles
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {doorC, estF, relC, teachS, skD, skE} = 6'h30;
    {de, ee, dl, tl, es} = 5'h05;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(32'hc601));
    tick(16);
    rst_n <= 1'b1;
    tick(1);
    verify();
    relC <= 1'b1;
    dl = 1'b0;
    verify();
    apb(1'b1, sim_pkg::OFF_CTRL, 32'h1);
    es = 1'b0;
    verify();
    apb(1'b0, sim_pkg::OFF_IRQST, 32'h0);
    // a set mask bit lets its status bit reach the interrupt line
    apb(1'b1, sim_pkg::OFF_IRQMSK, 32'h7);
    // door opens with release open: prohibit and latch
    relC <= 1'b0;
    doorC <= 1'b0;
    dl = 1'b1;
    verify();
    check({31'h0, irq}, 32'h1);
    apb(1'b0, sim_pkg::OFF_IRQST, 32'h0);
    check(rd, 32'h1 << sim_pkg::EV_DOOR);
    tick(2);
    check({31'h0, irq}, 32'h0);
    doorC <= 1'b1; // door closed before release
    verify();
    relC <= 1'b1;
    dl = 1'b0;
    verify();
    // teach latch, then cleared while the door is still open
    relC <= 1'b0;
    teachS <= 1'b1;
    tl = 1'b1;
    verify();
    doorC <= 1'b0;
    teachS <= 1'b0; // auto selected before release
    dl = 1'b1;
    verify();
    relC <= 1'b1;
    tl = 1'b0;
    verify();
    doorC <= 1'b1;
    relC <= 1'b0;
    verify();
    relC <= 1'b1;
    dl = 1'b0;
    verify();
    // status_a with the interrupt masked, then unmasked
    apb(1'b0, sim_pkg::OFF_IRQST, 32'h0);
    apb(1'b1, sim_pkg::OFF_IRQMSK, 32'hffffffff);
    apb(1'b0, sim_pkg::OFF_IRQMSK, 32'h0);
    check(rd, 32'h7);
    apb(1'b1, sim_pkg::OFF_IRQMSK, 32'h0);
    estF <= 1'b0;
    es = 1'b1;
    verify();
    check({31'h0, irq}, 32'h0);
    apb(1'b1, sim_pkg::OFF_IRQMSK, 32'h7);
    tick(2);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, sim_pkg::OFF_IRQST, 32'h0);
    check(rd, 32'h1 << sim_pkg::EV_STATUS_A);
    apb(1'b1, sim_pkg::OFF_CTRL, 32'h1);
    verify();
    estF <= 1'b1;
    verify();
    apb(1'b1, sim_pkg::OFF_CTRL, 32'h1);
    es = 1'b0;
    verify();
    // short random disagreements restart the timer and raise no critical error
    repeat (4) begin
      skD <= 1'b1;
      tick(1 + $urandom % 15);
      skD <= 1'b0;
      verify();
    end
    // long disagreements are critical and stay after the pair agrees again
    skD <= 1'b1;
    tick(40);
    skD <= 1'b0;
    tick(40);
    apb(1'b0, sim_pkg::OFF_STAT, 32'h0);
    check({31'h0, rd[sim_pkg::ST_DOOR_ERR]}, 32'h1);
    check({31'h0, critErr}, 32'h1);
    skE <= 1'b1;
    tick(40);
    skE <= 1'b0;
    tick(40);
    apb(1'b0, sim_pkg::OFF_STAT, 32'h0);
    check({31'h0, rd[sim_pkg::ST_STATUS_A_ERR]}, 32'h1);
    // unmapped word is refused
    apb(1'b1, 12'h010, 32'hffffffff);
    check({31'h0, errQ}, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    check(rd, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
